// ---- core/ast_timing_regs.v ----
// Timing and filter register slice with APB slave
//
// Local design decisions: the address map and the APB slave port.
`default_nettype none
`include "ast_map.vh"
module ast_timing_regs (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire trigger,
  input wire convert_done,
  input wire [17:0] accumulator_value,
  input wire [15:0] lpf_result,
  output reg precharge_active,
  output reg acquire_active,
  output reg convert_active,
  output reg [4:0] extra_capacitance_select,
  output reg threshold_check,
  output reg [15:0] filter_output_value
);
  reg [7:0] precharge_low;
  reg [4:0] precharge_high;
  reg [7:0] acquisition_time_low;
  reg [4:0] acquisition_time_high;
  reg [7:0] repeat_threshold;
  reg [7:0] trigger_counter;
  reg [5:0] clock_select;
  reg go;
  reg [2:0] computation_mode;
  reg [2:0] result_shift_amount;
  reg [31:0] next_rdata;
  reg hit;
  wire [12:0] precharge_count = {precharge_high, precharge_low};
  wire [12:0] acquisition_count = {acquisition_time_high, acquisition_time_low};
  wire tick;
  wire seq_pre;
  wire seq_acq;
  wire seq_conv;
  wire seq_busy;
  wire access = psel && penable && !pready;
  // Writes land at the completing edge, when the master samples pready
  wire wr = psel && penable && pready && pwrite;
  wire rd = access && !pwrite;
  // Triggers are honoured only while idle; a busy trigger would otherwise still bump trigger_counter
  wire start = trigger && go && !seq_busy;
  wire counting_mode = computation_mode == `AST_MODE_LPF ||
    computation_mode == `AST_MODE_AVG || computation_mode == `AST_MODE_BURST;
  wire cnt_written = wr && paddr == `AST_OFF_CNT;
  wire [7:0] next_count = trigger_counter + `AST_ONE8;
  wire [17:0] shifted = accumulator_value >> result_shift_amount;
  ast_clk_div u_div (
    .clock(clock),
    .rst(rst),
    .divide_select(clock_select),
    .tick(tick)
  );
  ast_phase_seq u_seq (
    .clock(clock),
    .rst(rst),
    .tick(tick),
    .start(start),
    .precharge_count(precharge_count),
    .acquisition_count(acquisition_count),
    .convert_done(convert_done),
    .precharge_active(seq_pre),
    .acquire_active(seq_acq),
    .convert_active(seq_conv),
    .busy(seq_busy)
  );
  always @* begin
    hit = 1'b1;
    next_rdata = `AST_ZERO32;
    case (paddr)
      `AST_OFF_PRE_LOW: next_rdata[7:0] = precharge_low;
      `AST_OFF_PRE_HIGH: next_rdata[4:0] = precharge_high;
      `AST_OFF_ACQ_LOW: next_rdata[7:0] = acquisition_time_low;
      `AST_OFF_ACQ_HIGH: next_rdata[4:0] = acquisition_time_high;
      `AST_OFF_CAP: next_rdata[4:0] = extra_capacitance_select;
      `AST_OFF_RPT: next_rdata[7:0] = repeat_threshold;
      `AST_OFF_CNT: next_rdata[7:0] = trigger_counter;
      `AST_OFF_FLT_HIGH: next_rdata[7:0] = filter_output_value[15:8];
      `AST_OFF_FLT_LOW: next_rdata[7:0] = filter_output_value[7:0];
      `AST_OFF_CLK_SEL: next_rdata[5:0] = clock_select;
      `AST_OFF_CTRL: begin
        next_rdata[`AST_CTRL_GO] = go;
        next_rdata[`AST_CTRL_MODE_MSB:`AST_CTRL_MODE_LSB] = computation_mode;
        next_rdata[`AST_CTRL_SHIFT_MSB:`AST_CTRL_SHIFT_LSB] = result_shift_amount;
      end
      `AST_OFF_STATUS: next_rdata[3:0] = {seq_conv, seq_acq, seq_pre, seq_busy};
      default: hit = 1'b0;
    endcase
  end
  always @(posedge clock) begin
    if (rst) begin
      prdata <= `AST_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // One wait state: answer the access phase in its second cycle
      pready <= access;
      pslverr <= access && !hit;
      prdata <= rd ? next_rdata : `AST_ZERO32;
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      precharge_low <= `AST_ZERO8;
      precharge_high <= `AST_ZERO5;
      acquisition_time_low <= `AST_ZERO8;
      acquisition_time_high <= `AST_ZERO5;
      extra_capacitance_select <= `AST_ZERO5;
      repeat_threshold <= `AST_ZERO8;
      clock_select <= `AST_ZERO6;
      go <= 1'b0;
      computation_mode <= `AST_MODE_BASIC;
      result_shift_amount <= `AST_ZERO3;
    end else if (wr) begin
      case (paddr)
        `AST_OFF_PRE_LOW: precharge_low <= pwdata[7:0];
        `AST_OFF_PRE_HIGH: precharge_high <= pwdata[4:0];
        `AST_OFF_ACQ_LOW: acquisition_time_low <= pwdata[7:0];
        `AST_OFF_ACQ_HIGH: acquisition_time_high <= pwdata[4:0];
        `AST_OFF_CAP: extra_capacitance_select <= pwdata[4:0];
        `AST_OFF_RPT: repeat_threshold <= pwdata[7:0];
        `AST_OFF_CLK_SEL: clock_select <= pwdata[5:0];
        `AST_OFF_CTRL: begin
          go <= pwdata[`AST_CTRL_GO];
          computation_mode <= pwdata[`AST_CTRL_MODE_MSB:`AST_CTRL_MODE_LSB];
          result_shift_amount <= pwdata[`AST_CTRL_SHIFT_MSB:`AST_CTRL_SHIFT_LSB];
        end
        default: go <= go; // Filter bytes are read only
      endcase
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      trigger_counter <= `AST_ZERO8;
      threshold_check <= 1'b0;
    end else begin
      threshold_check <= 1'b0;
      // A trigger in the same cycle as a software write wins
      if (start) begin
        trigger_counter <= next_count;
        if (!counting_mode || next_count >= repeat_threshold) begin
          threshold_check <= 1'b1;
        end
      end else if (cnt_written) begin
        trigger_counter <= pwdata[7:0];
      end
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      filter_output_value <= `AST_ZERO16;
      precharge_active <= 1'b0;
      acquire_active <= 1'b0;
      convert_active <= 1'b0;
    end else begin
      precharge_active <= seq_pre;
      acquire_active <= seq_acq;
      convert_active <= seq_conv;
      if (computation_mode == `AST_MODE_LPF) begin
        filter_output_value <= lpf_result;
      end else begin
        filter_output_value <= shifted[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/ast_map.vh ----
// Register map, field layout and timing constants for the sample timing block
`ifndef AST_MAP_VH
`define AST_MAP_VH
`define AST_OFF_PRE_LOW 12'h000
`define AST_OFF_PRE_HIGH 12'h004
`define AST_OFF_ACQ_LOW 12'h008
`define AST_OFF_ACQ_HIGH 12'h00c
`define AST_OFF_CAP 12'h010
`define AST_OFF_RPT 12'h014
`define AST_OFF_CNT 12'h018
`define AST_OFF_FLT_HIGH 12'h01c
`define AST_OFF_FLT_LOW 12'h020
`define AST_OFF_CLK_SEL 12'h024
`define AST_OFF_CTRL 12'h028
`define AST_OFF_STATUS 12'h02c
`define AST_CTRL_GO 0
`define AST_CTRL_MODE_LSB 4
`define AST_CTRL_MODE_MSB 6
`define AST_CTRL_SHIFT_LSB 8
`define AST_CTRL_SHIFT_MSB 10
`define AST_MODE_BASIC 3'h0
`define AST_MODE_ACCUM 3'h1
`define AST_MODE_AVG 3'h2
`define AST_MODE_BURST 3'h3
`define AST_MODE_LPF 3'h4
`define AST_ACQ_LONG 14'h2000
`define AST_HIGH_MASK 8'h1f
`define AST_ZERO8 8'h00
`define AST_ZERO13 13'h0000
`define AST_ONE13 13'h0001
`define AST_ZERO14 14'h0000
`define AST_ONE14 14'h0001
`define AST_ONE8 8'h01
`define AST_ZERO6 6'h00
`define AST_ONE6 6'h01
`define AST_ZERO16 16'h0000
`define AST_ZERO3 3'h0
`define AST_ZERO5 5'h00
`define AST_ZERO7 7'h00
`define AST_ONE7 7'h01
`define AST_ZERO32 32'h00000000
`endif

// ---- core/ast_clk_div.v ----
// Converter clock tick generator, even divide ratios
`default_nettype none
`include "ast_map.vh"
module ast_clk_div (
  input wire clock,
  input wire rst,
  input wire [5:0] divide_select,
  output reg tick
);
  // Two system clocks per select step: period is 2*(sel+1)
  reg [6:0] count;
  wire [6:0] limit = {divide_select, 1'b1};
  always @(posedge clock) begin
    if (rst) begin
      count <= `AST_ZERO7;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= `AST_ZERO7;
      tick <= 1'b1;
    end else begin
      count <= count + `AST_ONE7;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/ast_phase_seq.v ----
// Precharge, acquisition and conversion phase sequencer
`default_nettype none
`include "ast_map.vh"
module ast_phase_seq (
  input wire clock,
  input wire rst,
  input wire tick,
  input wire start,
  input wire [12:0] precharge_count,
  input wire [12:0] acquisition_count,
  input wire convert_done,
  output reg precharge_active,
  output reg acquire_active,
  output reg convert_active,
  output reg busy
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PRE = 4'h2;
  localparam [3:0] ST_ACQ = 4'h4;
  localparam [3:0] ST_CONV = 4'h8;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [13:0] remain;
  reg [13:0] next_remain;
  wire pre_on = precharge_count != `AST_ZERO13;
  // Acquisition length in converter clocks; zero means 8192 after a precharge, skip otherwise
  wire [13:0] acq_len = (acquisition_count != `AST_ZERO13) ? {1'b0, acquisition_count} :
    (pre_on ? `AST_ACQ_LONG : `AST_ZERO14);
  always @* begin
    next_state = state;
    next_remain = remain;
    case (state)
      ST_IDLE: begin
        if (start) begin
          if (pre_on) begin
            next_state = ST_PRE;
            next_remain = {1'b0, precharge_count};
          end else if (acq_len != `AST_ZERO14) begin
            next_state = ST_ACQ;
            next_remain = acq_len;
          end else begin
            next_state = ST_CONV;
          end
        end
      end
      ST_PRE: begin
        if (tick) begin
          if (remain == `AST_ONE14) begin
            next_state = ST_ACQ;
            next_remain = acq_len;
          end else begin
            next_remain = remain - `AST_ONE14;
          end
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (remain == `AST_ONE14) begin
            next_state = ST_CONV;
          end else begin
            next_remain = remain - `AST_ONE14;
          end
        end
      end
      ST_CONV: begin
        if (convert_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      remain <= `AST_ZERO14;
      precharge_active <= 1'b0;
      acquire_active <= 1'b0;
      convert_active <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      precharge_active <= next_state == ST_PRE;
      acquire_active <= next_state == ST_ACQ;
      convert_active <= next_state == ST_CONV;
      busy <= next_state != ST_IDLE;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ast_timing_chk.sv ----
// Port checker for the sample timing and filter register slice
`default_nettype none
`include "ast_map.vh"
module ast_timing_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger,
  input wire logic convert_done,
  input wire logic [17:0] accumulator_value,
  input wire logic [15:0] lpf_result,
  input wire logic precharge_active,
  input wire logic acquire_active,
  input wire logic convert_active,
  input wire logic [4:0] extra_capacitance_select,
  input wire logic threshold_check,
  input wire logic [15:0] filter_output_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [12:0] pre_h, acq_h;
  logic [5:0] sel_h;
  logic [2:0] mode_h, shift_h;
  int plen, alen, dv, ae;
  wire take = psel && penable && !pready;
  wire done_wr = psel && penable && pready && pwrite;
  // Zero acquisition with precharge present means the long phase
  assign dv = 2 * (sel_h + 1);
  assign ae = (acq_h != 13'h0) ? acq_h : 8192;
  always @(posedge clock) begin
    if (rst) begin
      {pre_h, acq_h, sel_h, mode_h, shift_h} <= 38'h0;
      plen <= 0;
      alen <= 0;
    end else begin
      plen <= precharge_active ? plen + 1 : 0;
      alen <= acquire_active ? alen + 1 : 0;
      if (done_wr) begin
        case (paddr)
          `AST_OFF_PRE_LOW: pre_h[7:0] <= pwdata[7:0];
          `AST_OFF_PRE_HIGH: pre_h[12:8] <= pwdata[4:0];
          `AST_OFF_ACQ_LOW: acq_h[7:0] <= pwdata[7:0];
          `AST_OFF_ACQ_HIGH: acq_h[12:8] <= pwdata[4:0];
          `AST_OFF_CLK_SEL: sel_h <= pwdata[5:0];
          `AST_OFF_CTRL: {shift_h, mode_h} <= {pwdata[10:8], pwdata[6:4]};
          default: ;
        endcase
      end
    end
  end
  a_ready_one_wait: assert property (take |=> pready ##1 !pready)
    else $error("bad pready");
  a_unmapped_refused: assert property (take && paddr > `AST_OFF_STATUS |=> pslverr && prdata == 0)
    else $error("unmapped not refused");
  a_cap_select_follows: assert property (
    done_wr && paddr == `AST_OFF_CAP |=> extra_capacitance_select == $past(pwdata[4:0]))
    else $error("bad cap select");
  a_filter_lowpass: assert property (
    !$past(rst) && $past(mode_h) == `AST_MODE_LPF |-> filter_output_value == $past(lpf_result))
    else $error("bad lpf output");
  a_filter_shifted: assert property (!$past(rst) && $past(mode_h) != `AST_MODE_LPF
    |-> filter_output_value == 16'($past(accumulator_value) >> $past(shift_h)))
    else $error("bad shifted output");
  a_precharge_length: assert property (
    $fell(precharge_active) |-> plen > (pre_h - 1) * dv && plen <= pre_h * dv + 1)
    else $error("bad precharge length");
  a_acquire_length: assert property (
    $fell(acquire_active) |-> alen > (ae - 1) * dv && alen <= ae * dv + 1)
    else $error("bad acquire length");
  a_pre_then_acq: assert property ($fell(precharge_active) |-> ##[0:1] acquire_active)
    else $error("no acquire after precharge");
  a_one_phase: assert property ($onehot0({precharge_active, acquire_active, convert_active}))
    else $error("phases overlap");
  c_write: cover property (take && pwrite);
  c_precharge: cover property ($fell(precharge_active));
  c_check: cover property (threshold_check);
endmodule
bind ast_timing_regs ast_timing_chk u_chk (.*);
`default_nettype wire

// ---- testbench/adc_sample_timing_and_filter_regs_tb_top.sv ----
// Self-checking bench for the sample timing and filter register slice
`default_nettype none
`include "ast_map.vh"
module adc_sample_timing_and_filter_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic trigger = 1'b0, convert_done = 1'b0, pready, pslverr, err, threshold_check;
  logic precharge_active, acquire_active, convert_active;
  logic [11:0] paddr = 12'h0, ad;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, h, seed = 32'h3026afd9;
  logic [17:0] accumulator_value = 18'h0;
  logic [15:0] lpf_result = 16'h0, filter_output_value;
  logic [4:0] extra_capacitance_select;
  int failures = 0, samples_checked = 0, cycles = 0, m, sh;
  // Four-state counters so an unknown phase output shows up in the compare
  integer pc = 0, ac = 0, hits = 0;
  ast_timing_regs dut (.*);
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    pc <= pc + precharge_active;
    ac <= ac + acquire_active;
    hits <= hits + threshold_check;
    if (cycles == 80000) begin
      failures++;
      wrap_up();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // High bytes and the capacitor byte keep five bits only
  function logic [31:0] msk(input logic [11:0] a);
    return (a == `AST_OFF_PRE_HIGH || a == `AST_OFF_ACQ_HIGH || a == `AST_OFF_CAP) ? 32'h1f : 32'hff;
  endfunction
  function logic [15:0] filt(input int md, input int s);
    return (md == 4) ? lpf_result : 16'(accumulator_value >> s);
  endfunction
  // Ticks may start early, so allow up to one tick short
  function automatic logic span(input int n, input int c, input logic [5:0] s);
    int dv;
    dv = 2 * (s + 1);
    return (n == 0) ? (c == 0) : (c > (n - 1) * dv && c <= n * dv + 1);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task conv(input int k, input logic [12:0] p, input logic [12:0] q, input logic [5:0] s);
    int p0, a0, h0;
    apb(1'b1, `AST_OFF_PRE_LOW, 32'(p[7:0]));
    apb(1'b1, `AST_OFF_PRE_HIGH, 32'(p[12:8]));
    apb(1'b1, `AST_OFF_ACQ_LOW, 32'(q[7:0]));
    apb(1'b1, `AST_OFF_ACQ_HIGH, 32'(q[12:8]));
    apb(1'b1, `AST_OFF_CLK_SEL, 32'(s));
    p0 = pc;
    a0 = ac;
    h0 = hits;
    trigger <= 1'b1;
    @(posedge clock);
    trigger <= 1'b0;
    while (convert_active !== 1'b1) @(posedge clock);
    convert_done <= 1'b1;
    @(posedge clock);
    convert_done <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(span(p, pc - p0, s)), 32'h1);
    chk(32'(span((q != 0 || p == 0) ? q : 8192, ac - a0, s)), 32'h1);
    chk(32'(hits - h0), 32'(k >= 3));
    apb(1'b0, `AST_OFF_CNT, 32'h0);
    chk(rd, 32'(k));
  endtask
  task wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 24; i++) begin
      ad = 12'(4 * (i % 6));
      d = (i < 6) ? 32'hffffffff : rnd();
      apb(1'b1, ad, d);
      apb(1'b0, ad, 32'h0);
      chk(rd, d & msk(ad));
      if (ad == `AST_OFF_CAP) chk(32'(extra_capacitance_select), d & 32'h1f);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    for (m = 0; m < 5; m++) begin
      sh = rnd() % 8;
      accumulator_value <= 18'(rnd());
      lpf_result <= 16'(rnd());
      apb(1'b1, `AST_OFF_CTRL, 32'(sh * 256 + m * 16));
      apb(1'b1, `AST_OFF_FLT_LOW, 32'hffffffff);
      chk(32'(err), 32'h0);
      apb(1'b0, `AST_OFF_FLT_HIGH, 32'h0);
      h = rd;
      apb(1'b0, `AST_OFF_FLT_LOW, 32'h0);
      chk({16'h0, h[7:0], rd[7:0]}, 32'(filt(m, sh)));
    end
    apb(1'b1, `AST_OFF_RPT, 32'h3);
    apb(1'b1, `AST_OFF_CNT, 32'h0);
    apb(1'b1, `AST_OFF_CTRL, 32'h21);
    conv(1, 13'h3, 13'h2, 6'h1);
    conv(2, 13'h0, 13'h0, 6'h0);
    conv(3, 13'h0, 13'h5, 6'h3);
    conv(4, 13'h2, 13'h0, 6'h0);
    apb(1'b1, `AST_OFF_RPT, 32'hff);
    apb(1'b1, `AST_OFF_CTRL, 32'h11);
    apb(1'b0, `AST_OFF_CTRL, 32'h0);
    chk(rd, 32'h11);
    // Accumulate mode ignores the threshold, so a high one must not hold the check back
    conv(5, 13'h1, 13'h1, 6'h2);
    apb(1'b0, `AST_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
